// *** rtl/fddr_consts.svh ***
// Constants for the floppy drive decode and rate select block
`ifndef FDDR_CONSTS_SVH
`define FDDR_CONSTS_SVH

// ==========================================================================
// Register indices (byte address = index * 4)
`define FDDR_IDX_DRIVE_OUT     10'h3F2
`define FDDR_IDX_TAPE_MEDIA    10'h3F3
`define FDDR_IDX_RATE_WRITE_SHIFT_FIELD  10'h3F4
`define FDDR_IDX_DATA_PORT     10'h3F5
`define FDDR_IDX_CFG_RATE      10'h3F7
`define FDDR_IDX_CFG_SIX       10'h3F8
`define FDDR_IDX_CFG_SEVEN     10'h3F9
`define FDDR_IDX_MODE_CTRL     10'h3FA
`define FDDR_IDX_STATUS        10'h3FB

// ==========================================================================
// Field positions
`define FDDR_DOR_RESET_N_BIT   2
`define FDDR_DOR_MOTOR_LSB     4
`define FDDR_DSR_LOW_POWER_BIT 6
`define FDDR_DSR_SW_RESET_BIT  7
`define FDDR_CR7_INV_LO_BIT    2
`define FDDR_CR7_INV_HI_BIT    3

// ==========================================================================
// Reset values
`define FDDR_DOR_RESET         8'h00
`define FDDR_DSR_RESET         8'h02
`define FDDR_RATE_RESET        2'h2
`define FDDR_START_TRACK_RESET 8'h00

// ==========================================================================
// Lanes driven on a tape/media read in normal mode, and on every other access
`define FDDR_LANES_NORMAL      8'h03
`define FDDR_LANES_ALL         8'hFF

// ==========================================================================
// Precompensation step counts (one step is 41.67 ns)
`define FDDR_STEP_PS           41670
`define FDDR_STEPS_DEF_1M      3'h1
`define FDDR_STEPS_DEF_OTHER   3'h3
`define FDDR_WRITE_SHIFT_FIELD_OFF_CODE  3'h7
`define FDDR_WRITE_SHIFT_FIELD_DEF_CODE  3'h0

// ==========================================================================
// Timing: clock period and least software reset duration
`define FDDR_CLK_NS            10
`define FDDR_SWRST_NS          100
`define FDDR_SWRST_CYC         ((`FDDR_SWRST_NS + `FDDR_CLK_NS - 1) / `FDDR_CLK_NS)

`endif

// *** rtl/fddr_drive_decode.sv ***
// External 2-to-4 drive select and motor decode, drives 0 and 1 swapped
`timescale 1ns/1ps
module fddr_drive_decode (
   // Drive output control fields
   input  wire logic [1:0] drive_field,
   input  wire logic [3:0] motor_en,
   // Encoded active-low cable outputs
   output logic            drive_sel_out_lo_n,
   output logic            drive_sel_out_hi_n,
   output logic            motor_on_out_a_n,
   output logic            motor_on_out_b_n
);

   // =======================================================================
   // Swapped encode: 00->01, 01->00, 10->10, 11->11 on (hi,lo)
   always_comb begin
      drive_sel_out_hi_n = drive_field[1];
      drive_sel_out_lo_n = ~(drive_field[1] ^ drive_field[0]);
      motor_on_out_a_n   = ~motor_en[drive_field];
      motor_on_out_b_n   = 1'b1;
   end

endmodule : fddr_drive_decode

// *** rtl/fddr_pkg.sv ***
// Types for the floppy drive decode and rate select block
package fddr_pkg;

   // =======================================================================
   // Data rate field codes
   typedef enum logic [1:0] {
      FDDR_RATE_500K = 2'b00,
      FDDR_RATE_300K = 2'b01,
      FDDR_RATE_250K = 2'b10,
      FDDR_RATE_1M   = 2'b11
   } fddr_rate_t;

   // =======================================================================
   // Whole state of the top module
   typedef struct packed {
      logic [7:0]  drive_output_control;
      logic [1:0]  tape;
      logic [7:0]  dsr;
      logic [1:0]  ccr_rate;
      fddr_rate_t  rate;
      logic [7:0]  cr6;
      logic [7:0]  cr7;
      logic        enh2;
      logic [7:0]  start_track;
      logic        lowpwr;
      logic [3:0]  swrst_cnt;
      logic [2:0]  sync_lo;
      logic [2:0]  sync_hi;
      logic [1:0]  media;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic [7:0]  lane_en;
      logic        sel_lo_n;
      logic        sel_hi_n;
      logic        mot_a_n;
      logic        mot_b_n;
      logic [1:0]  rate_pin_o;
      logic        rate_pin_oe;
      logic        ctrl_rst;
      logic [2:0]  steps;
      logic        write_shift_field_on;
      logic        fm_illegal;
   } fddr_state_t;

endpackage : fddr_pkg

// *** rtl/fddr_top.sv ***
// Floppy drive decode, tape/media register and data rate select over APB
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "fddr_consts.svh"
module fddr_top (
   // Clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,

   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [7:0]       prdata_lane_en,

   // Controller core side
   input  wire logic [7:0]  cur_track,
   input  wire logic        mfm_mode,
   output logic             ctrl_reset,
   output logic             ctrl_clk_stop,
   output logic [1:0]       active_rate,
   output logic             fm_rate_illegal,
   output logic [2:0]       write_shift_steps,
   output logic             write_shift_on,

   // Drive cable
   output logic             drive_sel_out_lo_n,
   output logic             drive_sel_out_hi_n,
   output logic             motor_on_out_a_n,
   output logic             motor_on_out_b_n,
   input  wire logic        rate_pin_lo_i,
   output logic             rate_pin_lo_o,
   output logic             rate_pin_lo_oe,
   input  wire logic        rate_pin_hi_i,
   output logic             rate_pin_hi_o,
   output logic             rate_pin_hi_oe
);

   // =======================================================================
   // State registers
   fddr_pkg::fddr_state_t q_r;
   fddr_pkg::fddr_state_t q_nxt;

   // Bus decode
   logic [9:0] idx;
   logic       acc;
   logic       done;

   // Helper block results
   logic       sel_lo_n_c;
   logic       sel_hi_n_c;
   logic       mot_a_n_c;
   logic       mot_b_n_c;
   logic [2:0] steps_c;
   logic       shift_on_c;

   // Word index of the access; the low address bits do not matter
   assign idx  = paddr[11:2];
   assign acc  = psel & penable;
   // Edge at which a transfer takes effect
   assign done = acc & q_r.pready;

   // =======================================================================
   // Address decode, used for the error flag only; every access gets pready
   // Data port and status are mapped for wake-up accesses
   function automatic logic idx_mapped(input logic [9:0] a);
      case (a)
         `FDDR_IDX_DRIVE_OUT,
         `FDDR_IDX_TAPE_MEDIA,
         `FDDR_IDX_RATE_WRITE_SHIFT_FIELD,
         `FDDR_IDX_DATA_PORT,
         `FDDR_IDX_CFG_RATE,
         `FDDR_IDX_CFG_SIX,
         `FDDR_IDX_CFG_SEVEN,
         `FDDR_IDX_MODE_CTRL,
         `FDDR_IDX_STATUS: idx_mapped = 1'b1;
         default:          idx_mapped = 1'b0;
      endcase
   endfunction : idx_mapped

   // =======================================================================
   // Two-bit pair of a byte picked by a drive field
   // Field 00 picks bits 1:0
   function automatic logic [1:0] pair_pick(input logic [7:0] v, input logic [1:0] f);
      pair_pick = v[{f, 1'b0} +: 2];
   endfunction : pair_pick

   // =======================================================================
   // Tape/media register image, built from the held state
   function automatic logic [7:0] tape_media_info(input fddr_pkg::fddr_state_t s);
      logic [7:0] v;
      // Normal mode: zero above bit 1, lanes mark it undriven
      v = {6'h00, s.tape};

      if (s.enh2) begin
         v[6]   = s.media[0] ^ s.cr7[`FDDR_CR7_INV_LO_BIT];
         v[7]   = s.media[1] ^ s.cr7[`FDDR_CR7_INV_HI_BIT];
         v[5:4] = pair_pick(s.cr6, s.drive_output_control[1:0]);
         v[3:2] = s.cr7[1:0];
      end
      tape_media_info = v;
   endfunction : tape_media_info

   // =======================================================================
   // Read data; write-only and data-port words read as zero
   // Status gathers the live settings for software
   function automatic logic [31:0] read_word(input fddr_pkg::fddr_state_t s,
                                             input logic [9:0] a);
      case (a)
         `FDDR_IDX_DRIVE_OUT:  read_word = {24'h00_0000, s.drive_output_control};
         `FDDR_IDX_TAPE_MEDIA: read_word = {24'h00_0000, tape_media_info(s)};
         `FDDR_IDX_CFG_SIX:    read_word = {24'h00_0000, s.cr6};
         `FDDR_IDX_CFG_SEVEN:  read_word = {24'h00_0000, s.cr7};
         `FDDR_IDX_MODE_CTRL:  read_word = {16'h0000, s.start_track, 7'h00, s.enh2};
         `FDDR_IDX_STATUS:     read_word = {23'h00_0000, s.fm_illegal, s.ctrl_rst,
                                            s.lowpwr, s.write_shift_field_on, s.steps, s.rate};
         default:              read_word = 32'h0000_0000;
      endcase
   endfunction : read_word

   // =======================================================================
   // Cable decode and precompensation selection from the next state
   fddr_drive_decode u_decode (
      .drive_field        (q_nxt.drive_output_control[1:0]),
      .motor_en           (q_nxt.drive_output_control[7:`FDDR_DOR_MOTOR_LSB]),
      .drive_sel_out_lo_n (sel_lo_n_c),
      .drive_sel_out_hi_n (sel_hi_n_c),
      .motor_on_out_a_n   (mot_a_n_c),
      .motor_on_out_b_n   (mot_b_n_c)
   );

   // Shift uses the settings after this edge
   fddr_write_shift_field u_write_shift_field (
      .write_shift_field (q_nxt.dsr[4:2]),
      .rate              (q_nxt.rate),
      .cur_track         (cur_track),
      .start_track       (q_nxt.start_track),
      .shift_steps       (steps_c),
      .shift_on          (shift_on_c)
   );

   // =======================================================================
   // Next state: bus answer, register writes, reset and power control
   always_comb begin
      q_nxt = q_r;

      // APB: one wait state, answer built in the first access cycle
      q_nxt.pready  = 1'b0;
      q_nxt.pslverr = 1'b0;
      // A raised pready blocks a second answer
      if (acc && !q_r.pready) begin
         q_nxt.pready  = 1'b1;
         q_nxt.pslverr = ~idx_mapped(idx);
         q_nxt.lane_en = `FDDR_LANES_ALL;
         if (!pwrite) begin
            q_nxt.prdata = read_word(q_r, idx);
            // Normal mode leaves the upper data lanes undriven
            if (idx == `FDDR_IDX_TAPE_MEDIA && !q_r.enh2) begin
               q_nxt.lane_en = `FDDR_LANES_NORMAL;
            end
         end
      end

      // Reset pulse counts down; writing bit 7 again restarts it
      if (q_r.swrst_cnt != 4'h0) begin
         q_nxt.swrst_cnt = q_r.swrst_cnt - 4'h1;
      end

      // Writes take effect at the edge where pready is sampled high
      if (done && pwrite) begin
         case (idx)
            `FDDR_IDX_DRIVE_OUT: begin
               q_nxt.drive_output_control = pwdata[7:0];
            end

            `FDDR_IDX_TAPE_MEDIA: begin
               // Plain storage, unused inside
               q_nxt.tape = pwdata[1:0];
            end

            `FDDR_IDX_RATE_WRITE_SHIFT_FIELD: begin
               // Bit 5 is stored as written; software keeps it zero
               q_nxt.dsr  = {1'b0, pwdata[6:0]};
               q_nxt.rate = fddr_pkg::fddr_rate_t'(pwdata[1:0]);
               if (pwdata[`FDDR_DSR_LOW_POWER_BIT]) begin
                  q_nxt.lowpwr = 1'b1;
               end
               if (pwdata[`FDDR_DSR_SW_RESET_BIT]) begin
                  // Bit 7 only starts the pulse
                  q_nxt.swrst_cnt = 4'(`FDDR_SWRST_CYC);
               end
            end

            `FDDR_IDX_CFG_RATE: begin
               q_nxt.ccr_rate = pwdata[1:0];
               q_nxt.rate     = fddr_pkg::fddr_rate_t'(pwdata[1:0]);
            end

            `FDDR_IDX_CFG_SIX:   q_nxt.cr6 = pwdata[7:0];
            `FDDR_IDX_CFG_SEVEN: q_nxt.cr7 = pwdata[7:0];

            `FDDR_IDX_MODE_CTRL: begin
               // Start track stands in for the configure command
               q_nxt.enh2        = pwdata[0];
               q_nxt.start_track = pwdata[15:8];
            end

            default: begin
               // Data port: an access only
            end
         endcase
      end

      // Status or data port access wakes the controller
      // Status access here means a read of the rate word
      if (done && ((idx == `FDDR_IDX_DATA_PORT) ||
                   (idx == `FDDR_IDX_RATE_WRITE_SHIFT_FIELD && !pwrite))) begin
         q_nxt.lowpwr = 1'b0;
      end

      // Controller reset: held by the output bit or the pulse
      q_nxt.ctrl_rst = ~q_nxt.drive_output_control[`FDDR_DOR_RESET_N_BIT] |
                       (q_nxt.swrst_cnt != 4'h0);

      // Reset also ends low power; stored registers are untouched
      if (q_nxt.ctrl_rst) begin
         q_nxt.lowpwr = 1'b0;
      end

      // Rate pin synchronisers; second and third stage must agree
      // Stage one feeds stage two only
      q_nxt.sync_lo = {q_r.sync_lo[1:0], rate_pin_lo_i};
      q_nxt.sync_hi = {q_r.sync_hi[1:0], rate_pin_hi_i};

      if (q_r.sync_lo[1] == q_r.sync_lo[2]) begin
         q_nxt.media[0] = q_r.sync_lo[2];
      end

      if (q_r.sync_hi[1] == q_r.sync_hi[2]) begin
         q_nxt.media[1] = q_r.sync_hi[2];
      end

      // Rate pins are outputs only outside enhanced mode 2
      q_nxt.rate_pin_o  = q_nxt.rate;
      q_nxt.rate_pin_oe = ~q_nxt.enh2;

      // Registered copies of the decode and write_shift_field results
      q_nxt.sel_lo_n   = sel_lo_n_c;
      q_nxt.sel_hi_n   = sel_hi_n_c;
      q_nxt.mot_a_n    = mot_a_n_c;
      q_nxt.mot_b_n    = mot_b_n_c;

      q_nxt.steps      = steps_c;
      q_nxt.write_shift_field_on = shift_on_c;

      // FM has no 1 Mbps rate
      q_nxt.fm_illegal = (q_nxt.rate == fddr_pkg::FDDR_RATE_1M) && !mfm_mode;
   end

   // =======================================================================
   // State register; hardware reset loads constants only
   // Media bits rejoin the pins a few edges after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r             <= '0;

         q_r.drive_output_control         <= `FDDR_DOR_RESET;
         q_r.dsr         <= `FDDR_DSR_RESET;
         q_r.ccr_rate    <= `FDDR_RATE_RESET;
         q_r.rate        <= fddr_pkg::FDDR_RATE_250K;
         q_r.start_track <= `FDDR_START_TRACK_RESET;
         q_r.ctrl_rst    <= 1'b1;
         q_r.lane_en     <= `FDDR_LANES_ALL;
         q_r.sel_lo_n    <= 1'b1;
         q_r.sel_hi_n    <= 1'b0;
         q_r.mot_a_n     <= 1'b1;
         q_r.mot_b_n     <= 1'b1;
         q_r.rate_pin_o  <= `FDDR_RATE_RESET;
         q_r.rate_pin_oe <= 1'b1;
         q_r.steps       <= `FDDR_STEPS_DEF_OTHER;
      end else if (clk_en) begin
         // A low clock enable freezes every flop
         q_r <= q_nxt;
      end
   end

   // =======================================================================
   // Outputs, each straight from the state register
   assign prdata             = q_r.prdata;
   assign pready             = q_r.pready;
   assign pslverr            = q_r.pslverr;
   assign prdata_lane_en     = q_r.lane_en;

   // Core side
   assign ctrl_reset         = q_r.ctrl_rst;
   assign ctrl_clk_stop      = q_r.lowpwr;
   assign active_rate        = q_r.rate;
   assign fm_rate_illegal    = q_r.fm_illegal;
   assign write_shift_steps  = q_r.steps;
   assign write_shift_on     = q_r.write_shift_field_on;

   // Drive cable
   assign drive_sel_out_lo_n = q_r.sel_lo_n;
   assign drive_sel_out_hi_n = q_r.sel_hi_n;
   assign motor_on_out_a_n   = q_r.mot_a_n;
   assign motor_on_out_b_n   = q_r.mot_b_n;
   assign rate_pin_lo_o      = q_r.rate_pin_o[0];
   assign rate_pin_hi_o      = q_r.rate_pin_o[1];
   assign rate_pin_lo_oe     = q_r.rate_pin_oe;
   assign rate_pin_hi_oe     = q_r.rate_pin_oe;

endmodule : fddr_top

// *** rtl/fddr_write_shift_field.sv ***
// Write precompensation step selection
`timescale 1ns/1ps
`include "fddr_consts.svh"
module fddr_write_shift_field (
   // Programmed settings
   input  wire logic [2:0]       write_shift_field,
   input  wire fddr_pkg::fddr_rate_t rate,
   // Track gating
   input  wire logic [7:0]       cur_track,
   input  wire logic [7:0]       start_track,
   // Result
   output logic [2:0]            shift_steps,
   output logic                  shift_on
);

   // =======================================================================
   // Code to step count; default code depends on the active rate
   always_comb begin
      if (write_shift_field == `FDDR_WRITE_SHIFT_FIELD_OFF_CODE) begin
         shift_steps = 3'h0;
      end else if (write_shift_field == `FDDR_WRITE_SHIFT_FIELD_DEF_CODE) begin
         shift_steps = (rate == fddr_pkg::FDDR_RATE_1M) ? `FDDR_STEPS_DEF_1M
                                                      : `FDDR_STEPS_DEF_OTHER;
      end else begin
         shift_steps = write_shift_field;
      end
      // Tracks below the start track are written without shift
      shift_on = (shift_steps != 3'h0) && (cur_track >= start_track);
   end

endmodule : fddr_write_shift_field

// *** testbench/fddr_chk.sv ***
// Port assertions for the drive decode and rate select top
`timescale 1ns/1ps
`include "fddr_consts.svh"
module fddr_chk (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic [7:0]  prdata_lane_en,
   // Core and cable
   input wire logic        ctrl_reset,
   input wire logic        ctrl_clk_stop,
   input wire logic [1:0]  active_rate,
   input wire logic        fm_rate_illegal,
   input wire logic [2:0]  write_shift_steps,
   input wire logic        write_shift_on,
   input wire logic        motor_on_out_b_n,
   input wire logic        rate_pin_lo_o,
   input wire logic        rate_pin_lo_oe,
   input wire logic        rate_pin_hi_o
);
   // =====================================================================
   // Helpers
   // A completed transfer is the point where a register write or read takes effect
   wire [9:0] idx  = paddr[11:2];
   wire       done = psel && penable && pready;
   wire       dsr  = done && (idx == `FDDR_IDX_RATE_WRITE_SHIFT_FIELD);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =====================================================================
   // Properties
   property p_pready; pready |=> !pready; endproperty
   a_pready: assert property (p_pready) else $error("pready longer than one cycle");
   property p_motor_b; motor_on_out_b_n; endproperty
   a_motor_b: assert property (p_motor_b) else $error("motor b output went low");
   property p_pins; rate_pin_lo_oe |-> {rate_pin_hi_o, rate_pin_lo_o} == active_rate; endproperty
   a_pins: assert property (p_pins) else $error("rate pins differ from rate");
   property p_lanes;
      done && !pwrite && idx == `FDDR_IDX_TAPE_MEDIA && rate_pin_lo_oe
         |-> prdata_lane_en == 8'h03 && prdata[7:2] == 6'h00;
   endproperty
   a_lanes: assert property (p_lanes) else $error("normal mode drove upper bits");
   property p_dsr_rd; dsr && !pwrite |-> prdata == 32'h0; endproperty
   a_dsr_rd: assert property (p_dsr_rd) else $error("rate register readable");
   property p_swrst; dsr && pwrite && pwdata[7] |=> ctrl_reset [*8]; endproperty
   a_swrst: assert property (p_swrst) else $error("software reset too short");
   property p_lowpwr; dsr && pwrite && pwdata[7:6] == 2'b01 |=> ctrl_clk_stop; endproperty
   a_lowpwr: assert property (p_lowpwr) else $error("low power not entered");
   property p_lp_exit; dsr && !pwrite |=> !ctrl_clk_stop; endproperty
   a_lp_exit: assert property (p_lp_exit) else $error("low power kept after read");
   property p_fm; fm_rate_illegal |-> active_rate == 2'b11; endproperty
   a_fm: assert property (p_fm) else $error("fm flag at legal rate");
   property p_shift; write_shift_on |-> write_shift_steps != 3'h0; endproperty
   a_shift: assert property (p_shift) else $error("shift on with zero steps");
endmodule : fddr_chk

bind fddr_top fddr_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .prdata_lane_en, .ctrl_reset, .ctrl_clk_stop, .active_rate,
   .fm_rate_illegal, .write_shift_steps, .write_shift_on, .motor_on_out_b_n,
   .rate_pin_lo_o, .rate_pin_lo_oe, .rate_pin_hi_o);

// *** testbench/fddr_drive_model.sv ***
// Drive cable model: media sense levels on the shared rate pins
`timescale 1ns/1ps
module fddr_drive_model (
   // Controller pin drive
   input  wire logic       rate_pin_lo_o,
   input  wire logic       rate_pin_lo_oe,
   input  wire logic       rate_pin_hi_o,
   input  wire logic       rate_pin_hi_oe,
   // Media sense levels of the inserted disk
   input  wire logic [1:0] media,
   // Wire levels back to the controller
   output logic            rate_pin_lo_i,
   output logic            rate_pin_hi_i
);
   // =====================================================================
   // Pin resolution
   // The drive only puts its media code on a wire the controller released
   assign rate_pin_lo_i = rate_pin_lo_oe ? rate_pin_lo_o : media[0];
   assign rate_pin_hi_i = rate_pin_hi_oe ? rate_pin_hi_o : media[1];
endmodule : fddr_drive_model

// *** testbench/fddr_top_tb_top.sv ***
// Self-checking bench for the drive decode and rate select block
`timescale 1ns/1ps
`include "fddr_consts.svh"
module fddr_top_tb_top;
   // =====================================================================
   // Signals
   logic        pclk, presetn, clk_en, mfm_mode, psel, penable, pwrite, pready, pslverr, err;
   logic        ctrl_reset, ctrl_clk_stop, fm_rate_illegal, write_shift_on;
   logic        drive_sel_out_lo_n, drive_sel_out_hi_n, motor_on_out_a_n, motor_on_out_b_n;
   logic        rate_pin_lo_i, rate_pin_lo_o, rate_pin_lo_oe;
   logic        rate_pin_hi_i, rate_pin_hi_o, rate_pin_hi_oe;
   logic [1:0]  active_rate, media;
   logic [2:0]  write_shift_steps;
   logic [7:0]  cur_track, prdata_lane_en, lanes;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          n_mismatch, num_checks;
   localparam logic [1:0] SEL_TAB [4] = '{2'b01, 2'b00, 2'b10, 2'b11};
   // Clock
   always #5 pclk = ~pclk;
   fddr_top DUT (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .prdata_lane_en, .cur_track, .mfm_mode, .ctrl_reset,
      .ctrl_clk_stop, .active_rate, .fm_rate_illegal, .write_shift_steps, .write_shift_on,
      .drive_sel_out_lo_n, .drive_sel_out_hi_n, .motor_on_out_a_n, .motor_on_out_b_n,
      .rate_pin_lo_i, .rate_pin_lo_o, .rate_pin_lo_oe, .rate_pin_hi_i, .rate_pin_hi_o,
      .rate_pin_hi_oe);
   fddr_drive_model u_drv (.rate_pin_lo_o, .rate_pin_lo_oe, .rate_pin_hi_o,
      .rate_pin_hi_oe, .media, .rate_pin_lo_i, .rate_pin_hi_i);
   // =====================================================================
   // Tasks
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; answer taken at the rising edge that sees pready
   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
         if (n > 20) begin
            n_mismatch++;
            stop_test();
         end
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      lanes = prdata_lane_en;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask : apb
   // Hang guard
   initial begin
      repeat (100000) @(posedge pclk);
      n_mismatch++;
      stop_test();
   end
   // =====================================================================
   // Main sequence
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata, cur_track, media} = '0;
      {clk_en, mfm_mode, n_mismatch, num_checks} = '0;
      clk_en = 1'b1;
      mfm_mode = 1'b1;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // The release edge still resets; outputs settle one edge later
      repeat (2) @(negedge pclk);
      chk({drive_sel_out_hi_n, drive_sel_out_lo_n}, 2'b01);
      chk(active_rate, 2'h2);
      chk(write_shift_steps, 3'h3);
      chk(write_shift_on, 1'b1);
      chk(ctrl_reset, 1'b1);
      apb(0, `FDDR_IDX_RATE_WRITE_SHIFT_FIELD, 32'h0);
      chk(rd, 32'h0);
      apb(0, 10'h000, 32'h0);
      chk(err, 1'b1);
      apb(1, `FDDR_IDX_DRIVE_OUT, 32'h04);
      chk(ctrl_reset, 1'b0);
      $display("test reset done");
      apb(1, `FDDR_IDX_MODE_CTRL, 32'h01);
      chk({rate_pin_hi_oe, rate_pin_lo_oe}, 2'b00);
      apb(1, `FDDR_IDX_CFG_SIX, 32'hE4);
      for (int f = 0; f < 4; f++) begin
         apb(1, `FDDR_IDX_DRIVE_OUT, (32'h10 << f) | 32'h04 | f);
         chk({drive_sel_out_hi_n, drive_sel_out_lo_n}, SEL_TAB[f]);
         chk(motor_on_out_a_n, 1'b0);
         apb(0, `FDDR_IDX_TAPE_MEDIA, 32'h0);
         chk(rd[5:4], f);
         apb(1, `FDDR_IDX_DRIVE_OUT, (32'hF4 & ~(32'h10 << f)) | f);
         chk(motor_on_out_a_n, 1'b1);
      end
      $display("test decode done");
      for (int i = 0; i < 16; i++) begin
         @(posedge pclk);
         media <= i[1:0];
         apb(1, `FDDR_IDX_CFG_SEVEN, {28'h0, i[3:2], 2'b01});
         apb(1, `FDDR_IDX_TAPE_MEDIA, i[1:0]);
         apb(0, `FDDR_IDX_TAPE_MEDIA, 32'h0);
         chk(rd[7:6], i[1:0] ^ i[3:2]);
         chk(rd[3:0], {2'b01, i[1:0]});
      end
      $display("test media done");
      apb(1, `FDDR_IDX_RATE_WRITE_SHIFT_FIELD, 32'h83);
      chk(ctrl_reset, 1'b1);
      repeat (12) @(negedge pclk);
      chk(ctrl_reset, 1'b0);
      apb(0, `FDDR_IDX_TAPE_MEDIA, 32'h0);
      chk(rd[7:0], 8'h37);
      chk(write_shift_steps, 3'h1);
      $display("test soft reset done");
      apb(1, `FDDR_IDX_MODE_CTRL, 32'h00);
      chk({rate_pin_hi_oe, rate_pin_lo_oe}, 2'b11);
      apb(0, `FDDR_IDX_TAPE_MEDIA, 32'h0);
      chk(rd[7:0], 8'h03);
      chk(lanes, 8'h03);
      @(posedge pclk);
      mfm_mode <= 1'b0;
      for (int r = 0; r < 4; r++) begin
         apb(1, `FDDR_IDX_RATE_WRITE_SHIFT_FIELD, r);
         chk(active_rate, r);
         chk({rate_pin_hi_o, rate_pin_lo_o}, r);
         chk(fm_rate_illegal, r == 3);
         chk(write_shift_steps, (r == 3) ? 1 : 3);
      end
      for (int p = 1; p < 8; p++) begin
         apb(1, `FDDR_IDX_RATE_WRITE_SHIFT_FIELD, (p << 2) | 2);
         chk(write_shift_steps, (p == 7) ? 0 : p);
         chk(write_shift_on, p != 7);
      end
      apb(1, `FDDR_IDX_CFG_RATE, 32'h1);
      chk(active_rate, 2'h1);
      apb(1, `FDDR_IDX_RATE_WRITE_SHIFT_FIELD, 32'h3);
      chk(active_rate, 2'h3);
      apb(1, `FDDR_IDX_MODE_CTRL, 32'h0000_0500);
      chk(write_shift_on, 1'b0);
      @(posedge pclk);
      cur_track <= 8'h05;
      repeat (2) @(negedge pclk);
      chk(write_shift_on, 1'b1);
      $display("test rate done");
      apb(1, `FDDR_IDX_RATE_WRITE_SHIFT_FIELD, 32'h42);
      chk(ctrl_clk_stop, 1'b1);
      apb(0, `FDDR_IDX_RATE_WRITE_SHIFT_FIELD, 32'h0);
      chk(ctrl_clk_stop, 1'b0);
      apb(1, `FDDR_IDX_RATE_WRITE_SHIFT_FIELD, 32'h41);
      apb(0, `FDDR_IDX_DATA_PORT, 32'h0);
      chk(ctrl_clk_stop, 1'b0);
      apb(1, `FDDR_IDX_DRIVE_OUT, 32'h00);
      chk(ctrl_reset, 1'b1);
      chk(active_rate, 2'h1);
      apb(1, `FDDR_IDX_DRIVE_OUT, 32'h04);
      chk(ctrl_reset, 1'b0);
      $display("test low power done");
      stop_test();
   end
endmodule : fddr_top_tb_top
